// file: rtl/sfq_pkg.sv
/*
  Package for the serial port FIFO status and interrupt block: register
  indices and byte addresses, field positions, reset values, the register
  select enumeration and the character carrier struct.
  Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
*/
package sfq_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] TX_CTRL_IDX = 16'h705A;
  localparam logic [15:0] RX_CTRL_IDX = 16'h705B;
  localparam logic [15:0] RX_DATA_IDX = 16'h7057;
  localparam logic [15:0] TX_DATA_IDX = 16'h7059;
  localparam logic [15:0] IRQ_STAT_IDX = 16'h7060;
  localparam logic [15:0] IRQ_MASK_IDX = 16'h7061;
  localparam logic [31:0] TX_CTRL_ADDR = {14'h0000, TX_CTRL_IDX, 2'b00};
  localparam logic [31:0] RX_CTRL_ADDR = {14'h0000, RX_CTRL_IDX, 2'b00};
  localparam logic [31:0] RX_DATA_ADDR = {14'h0000, RX_DATA_IDX, 2'b00};
  localparam logic [31:0] TX_DATA_ADDR = {14'h0000, TX_DATA_IDX, 2'b00};
  localparam logic [31:0] IRQ_STAT_ADDR = {14'h0000, IRQ_STAT_IDX, 2'b00};
  localparam logic [31:0] IRQ_MASK_ADDR = {14'h0000, IRQ_MASK_IDX, 2'b00};

  // Control register fields; port reset and FIFO enable are transmit only, overflow is receive only
  localparam int unsigned PORT_RST_BIT = 15;
  localparam int unsigned FIFO_ENA_BIT = 14;
  localparam int unsigned OVF_FLAG_BIT = 15;
  localparam int unsigned OVF_CLR_BIT = 14;
  localparam int unsigned PTR_RST_BIT = 13;
  localparam int unsigned COUNT_LSB = 8;
  localparam int unsigned IRQ_FLAG_BIT = 7;
  localparam int unsigned IRQ_CLR_BIT = 6;
  localparam int unsigned IRQ_ENA_BIT = 5;
  localparam int unsigned THR_LSB = 0;

  // Interrupt status and mask layout
  localparam int unsigned IRQ_TX_BIT = 0;
  localparam int unsigned IRQ_RX_BIT = 1;

  // Geometry
  localparam int unsigned DEPTH = 16;
  localparam int unsigned PTR_W = 4;
  localparam int unsigned CNT_W = 5;
  localparam int unsigned CHAR_W = 8;
  localparam logic [4:0] CNT_FULL = 5'h10;

  // Reset values
  localparam logic [4:0] TX_THR_RST = 5'h00;
  localparam logic [4:0] RX_THR_RST = 5'h1F;

  typedef enum logic [2:0] {
    REG_NONE = 3'b000,
    REG_TXCTL = 3'b001,
    REG_RXCTL = 3'b010,
    REG_TXDAT = 3'b011,
    REG_RXDAT = 3'b100,
    REG_ISTAT = 3'b101,
    REG_IMASK = 3'b110
  } sfq_reg_e;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } sfq_char_s;

endpackage

// file: rtl/sfq_top.sv
/*
  Transmit and receive FIFOs of an asynchronous serial port with their
  fill counts, level interrupts, receive overflow flag, pointer resets
  and an AHB-Lite register slave.
  Assumes the shift logic is synchronous to clk_i; the bus is single-slave.
*/
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns

module sfq_fifo #(
  parameter bit OVERWRITE = 1'b0
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic flush_i,
  input wire logic push_i,
  input wire logic [7:0] data_i,
  input wire logic pop_i,
  output logic [7:0] data_o,
  output logic [4:0] count_o,
  output logic drop_o
);
  logic [7:0] mem [sfq_pkg::DEPTH];
  logic [3:0] rd_ptr;
  logic [3:0] wr_ptr;
  logic full;
  logic do_pop;
  logic do_push;

  assign full = (count_o == sfq_pkg::CNT_FULL);
  assign do_pop = pop_i && (count_o != 5'h00);
  assign do_push = push_i && (!full || OVERWRITE || do_pop);
  assign drop_o = push_i && full && !do_pop && OVERWRITE && !flush_i;
  assign data_o = mem[rd_ptr];

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_ptr <= 4'h0;
      wr_ptr <= 4'h0;
      count_o <= 5'h00;
    end else if (flush_i) begin
      rd_ptr <= 4'h0;
      wr_ptr <= 4'h0;
      count_o <= 5'h00;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 4'h1;
      end
      if (do_pop || drop_o) begin
        rd_ptr <= rd_ptr + 4'h1;
      end
      if (do_push && !(do_pop || drop_o)) begin
        count_o <= count_o + 5'h01;
      end else if (!do_push && do_pop) begin
        count_o <= count_o - 5'h01;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < sfq_pkg::DEPTH; i++) begin
        mem[i] <= 8'h00;
      end
    end else if (do_push && !flush_i) begin
      mem[wr_ptr] <= data_i;
    end
  end

  a_count_bound: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    count_o <= sfq_pkg::CNT_FULL)
    else $error("fifo count above sixteen");
  a_flush_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    flush_i |=> (count_o == 5'h00))
    else $error("fifo count not held at zero during pointer reset");
  a_full_ignore: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (full && push_i && !pop_i && !flush_i) |=> (count_o == sfq_pkg::CNT_FULL) && $stable(wr_ptr) == !OVERWRITE)
    else $error("push into full fifo handled wrongly");

endmodule // sfq_fifo

module sfq_top (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output sfq_pkg::sfq_char_s tx_char_o,
  input wire logic tx_ready_i,
  input wire sfq_pkg::sfq_char_s rx_char_i,
  output logic irq_o
);
  sfq_pkg::sfq_reg_e dp_reg;
  sfq_pkg::sfq_reg_e next_reg;
  logic dp_write;
  logic port_rst;
  logic fifo_ena;
  logic tx_ptr_run;
  logic rx_ptr_run;
  logic tx_en;
  logic rx_en;
  logic [4:0] tx_thr;
  logic [4:0] rx_thr;
  logic tx_flag;
  logic rx_flag;
  logic ovf_flag;
  logic [7:0] rx_last;
  logic [7:0] tx_head;
  logic [7:0] rx_head;
  logic [4:0] tx_count;
  logic [4:0] rx_count;
  logic rx_drop;
  logic wr_txctl;
  logic wr_rxctl;
  logic wr_istat;
  logic wr_imask;
  logic tx_push;
  logic tx_pop;
  logic rx_pop;
  logic tx_match;
  logic rx_match;

  // Address phase decode, captured for the data phase
  always_comb begin
    next_reg = sfq_pkg::REG_NONE;
    unique case (haddr_i)
      sfq_pkg::TX_CTRL_ADDR: next_reg = sfq_pkg::REG_TXCTL;
      sfq_pkg::RX_CTRL_ADDR: next_reg = sfq_pkg::REG_RXCTL;
      sfq_pkg::TX_DATA_ADDR: next_reg = sfq_pkg::REG_TXDAT;
      sfq_pkg::RX_DATA_ADDR: next_reg = sfq_pkg::REG_RXDAT;
      sfq_pkg::IRQ_STAT_ADDR: next_reg = sfq_pkg::REG_ISTAT;
      sfq_pkg::IRQ_MASK_ADDR: next_reg = sfq_pkg::REG_IMASK;
      default: next_reg = sfq_pkg::REG_NONE;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dp_reg <= sfq_pkg::REG_NONE;
      dp_write <= 1'b0;
    end else if (hready_i) begin
      if (hsel_i && htrans_i[1]) begin
        dp_reg <= next_reg;
        dp_write <= hwrite_i;
      end else begin
        dp_reg <= sfq_pkg::REG_NONE;
        dp_write <= 1'b0;
      end
    end
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  assign wr_txctl = dp_write && (dp_reg == sfq_pkg::REG_TXCTL);
  assign wr_rxctl = dp_write && (dp_reg == sfq_pkg::REG_RXCTL);
  assign wr_istat = dp_write && (dp_reg == sfq_pkg::REG_ISTAT);
  assign wr_imask = dp_write && (dp_reg == sfq_pkg::REG_IMASK);
  assign tx_push = dp_write && (dp_reg == sfq_pkg::REG_TXDAT);
  assign rx_pop = !dp_write && (dp_reg == sfq_pkg::REG_RXDAT);
  assign tx_pop = tx_ready_i && tx_char_o.valid;

  sfq_fifo #(
    .OVERWRITE(1'b0)
  ) u_tx_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .flush_i(!tx_ptr_run),
    .push_i(tx_push),
    .data_i(hwdata_i[7:0]),
    .pop_i(tx_pop),
    .data_o(tx_head),
    .count_o(tx_count),
    .drop_o()
  );

  sfq_fifo #(
    .OVERWRITE(1'b1)
  ) u_rx_fifo (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .flush_i(!rx_ptr_run),
    .push_i(rx_char_i.valid),
    .data_i(rx_char_i.data),
    .pop_i(rx_pop),
    .data_o(rx_head),
    .count_o(rx_count),
    .drop_o(rx_drop)
  );

  assign tx_char_o.valid = (tx_count != 5'h00);
  assign tx_char_o.data = tx_head;

  // Control fields; port reset and FIFO enable are kept for software only
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      port_rst <= 1'b1;
      fifo_ena <= 1'b0;
      tx_ptr_run <= 1'b1;
      tx_thr <= sfq_pkg::TX_THR_RST;
    end else if (wr_txctl) begin
      port_rst <= hwdata_i[sfq_pkg::PORT_RST_BIT];
      fifo_ena <= hwdata_i[sfq_pkg::FIFO_ENA_BIT];
      tx_ptr_run <= hwdata_i[sfq_pkg::PTR_RST_BIT];
      tx_thr <= hwdata_i[sfq_pkg::THR_LSB +: sfq_pkg::CNT_W];
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_ptr_run <= 1'b1;
      rx_thr <= sfq_pkg::RX_THR_RST;
    end else if (wr_rxctl) begin
      rx_ptr_run <= hwdata_i[sfq_pkg::PTR_RST_BIT];
      rx_thr <= hwdata_i[sfq_pkg::THR_LSB +: sfq_pkg::CNT_W];
    end
  end

  // Enables reachable through the control registers and the mask register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_en <= 1'b0;
      rx_en <= 1'b0;
    end else begin
      if (wr_txctl) begin
        tx_en <= hwdata_i[sfq_pkg::IRQ_ENA_BIT];
      end else if (wr_imask) begin
        tx_en <= hwdata_i[sfq_pkg::IRQ_TX_BIT];
      end
      if (wr_rxctl) begin
        rx_en <= hwdata_i[sfq_pkg::IRQ_ENA_BIT];
      end else if (wr_imask) begin
        rx_en <= hwdata_i[sfq_pkg::IRQ_RX_BIT];
      end
    end
  end

  assign tx_match = (tx_count <= tx_thr);
  assign rx_match = (rx_count >= rx_thr);

  // Sticky flags; a level match in the clearing cycle keeps the flag set
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_flag <= 1'b0;
      rx_flag <= 1'b0;
      ovf_flag <= 1'b0;
    end else begin
      if (tx_match) begin
        tx_flag <= 1'b1;
      end else if ((wr_txctl && hwdata_i[sfq_pkg::IRQ_CLR_BIT]) ||
                   (wr_istat && hwdata_i[sfq_pkg::IRQ_TX_BIT])) begin
        tx_flag <= 1'b0;
      end
      if (rx_match) begin
        rx_flag <= 1'b1;
      end else if ((wr_rxctl && hwdata_i[sfq_pkg::IRQ_CLR_BIT]) ||
                   (wr_istat && hwdata_i[sfq_pkg::IRQ_RX_BIT])) begin
        rx_flag <= 1'b0;
      end
      if (rx_drop) begin
        ovf_flag <= 1'b1;
      end else if (wr_rxctl && hwdata_i[sfq_pkg::OVF_CLR_BIT]) begin
        ovf_flag <= 1'b0;
      end
    end
  end

  // Overflow is not part of the request
  assign irq_o = (tx_flag && tx_en) || (rx_flag && rx_en);

  // Last character handed to software, repeated when the FIFO is empty
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_last <= 8'h00;
    end else if (rx_pop && (rx_count != 5'h00)) begin
      rx_last <= rx_head;
    end
  end

  // Read data; clear bits always read as zero
  always_comb begin
    hrdata_o = 32'h0000_0000;
    unique case (dp_reg)
      sfq_pkg::REG_TXCTL: begin
        hrdata_o[sfq_pkg::PORT_RST_BIT] = port_rst;
        hrdata_o[sfq_pkg::FIFO_ENA_BIT] = fifo_ena;
        hrdata_o[sfq_pkg::PTR_RST_BIT] = tx_ptr_run;
        hrdata_o[sfq_pkg::COUNT_LSB +: sfq_pkg::CNT_W] = tx_count;
        hrdata_o[sfq_pkg::IRQ_FLAG_BIT] = tx_flag;
        hrdata_o[sfq_pkg::IRQ_ENA_BIT] = tx_en;
        hrdata_o[sfq_pkg::THR_LSB +: sfq_pkg::CNT_W] = tx_thr;
      end
      sfq_pkg::REG_RXCTL: begin
        hrdata_o[sfq_pkg::OVF_FLAG_BIT] = ovf_flag;
        hrdata_o[sfq_pkg::PTR_RST_BIT] = rx_ptr_run;
        hrdata_o[sfq_pkg::COUNT_LSB +: sfq_pkg::CNT_W] = rx_count;
        hrdata_o[sfq_pkg::IRQ_FLAG_BIT] = rx_flag;
        hrdata_o[sfq_pkg::IRQ_ENA_BIT] = rx_en;
        hrdata_o[sfq_pkg::THR_LSB +: sfq_pkg::CNT_W] = rx_thr;
      end
      sfq_pkg::REG_RXDAT: begin
        hrdata_o[7:0] = (rx_count != 5'h00) ? rx_head : rx_last;
      end
      sfq_pkg::REG_ISTAT: begin
        hrdata_o[sfq_pkg::IRQ_TX_BIT] = tx_flag;
        hrdata_o[sfq_pkg::IRQ_RX_BIT] = rx_flag;
      end
      sfq_pkg::REG_IMASK: begin
        hrdata_o[sfq_pkg::IRQ_TX_BIT] = tx_en;
        hrdata_o[sfq_pkg::IRQ_RX_BIT] = rx_en;
      end
      sfq_pkg::REG_TXDAT, sfq_pkg::REG_NONE: begin
        hrdata_o = 32'h0000_0000;
      end
      default: hrdata_o = 32'h0000_0000;
    endcase
  end

  a_tx_flag_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tx_match |=> tx_flag)
    else $error("transmit flag missed a level match");
  a_rx_flag_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (rx_count >= rx_thr) |=> rx_flag)
    else $error("receive flag missed a level match");
  a_tx_flag_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (wr_txctl && hwdata_i[sfq_pkg::IRQ_CLR_BIT] && !tx_match) |=> !tx_flag)
    else $error("transmit flag not cleared");
  a_ovf_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (rx_count == sfq_pkg::CNT_FULL && rx_char_i.valid && !rx_pop && rx_ptr_run) |=>
      ovf_flag && rx_count == sfq_pkg::CNT_FULL)
    else $error("overflow not flagged on seventeenth word");
  a_ovf_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (wr_rxctl && hwdata_i[sfq_pkg::OVF_CLR_BIT] && !rx_drop) |=> !ovf_flag)
    else $error("overflow flag not cleared");
  a_ovf_no_irq: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    irq_o |-> ((tx_flag && tx_en) || (rx_flag && rx_en)))
    else $error("interrupt raised without an enabled flag");
  a_irq_follows: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (rx_flag && rx_en) |-> irq_o)
    else $error("interrupt low with enabled receive flag");
  a_clr_reads_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (dp_reg == sfq_pkg::REG_RXCTL) |->
      (hrdata_o[sfq_pkg::IRQ_CLR_BIT] == 1'b0 && hrdata_o[sfq_pkg::OVF_CLR_BIT] == 1'b0))
    else $error("clear bits read back nonzero");
  a_rx_hold_reset: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !rx_ptr_run |=> (rx_count == 5'h00))
    else $error("receive count not held at zero");

endmodule // sfq_top

// file: tb/sfq_shift_model.sv
/*
  Model of the serial shift logic: takes transmit characters and
  delivers received characters.
  Assumes the same clock as the block and calls of send just after a rising edge.
*/
`timescale 1ns/1ns

module sfq_shift_model (
  input wire logic clk_i,
  input wire sfq_pkg::sfq_char_s tx_char_i,
  input wire logic stall_i,
  output logic tx_ready_o,
  output sfq_pkg::sfq_char_s rx_char_o
);
  logic [7:0] taken_q[$];

  initial begin
    rx_char_o = '0;
  end

  // Transmit side takes the head whenever it is not stalled
  assign tx_ready_o = !stall_i;

  always @(posedge clk_i) begin
    if (tx_char_i.valid === 1'b1 && tx_ready_o) begin
      taken_q.push_back(tx_char_i.data);
    end
  end

  // Receive burst, one character per cycle; idle data is the inverse of the last
  task automatic send(input int n, input logic [7:0] base);
    logic [7:0] d;
    d = base;
    for (int i = 0; i < n; i++) begin
      d = base + 8'(i);
      rx_char_o <= '{valid: 1'b1, data: d};
      @(posedge clk_i);
    end
    rx_char_o <= '{valid: 1'b0, data: ~d};
  endtask
endmodule // sfq_shift_model

// file: tb/tb_serial_port_fifo_status_irq.sv
/*
  Self-checking testbench for the serial port FIFO status block.
  Assumes a single AHB-Lite slave and the shift logic model beside it.
*/
`timescale 1ns/1ns

module tb_serial_port_fifo_status_irq;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic stall = 1'b1;
  logic tx_ready;
  logic irq;
  sfq_pkg::sfq_char_s tx_char;
  sfq_pkg::sfq_char_s rx_char;
  logic [31:0] rd;
  int fail_count = 0;
  int checks = 0;

  always #25 clk_i = ~clk_i;

  sfq_top i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .tx_char_o(tx_char), .tx_ready_i(tx_ready), .rx_char_i(rx_char), .irq_o(irq));

  sfq_shift_model i_model (.clk_i(clk_i), .tx_char_i(tx_char), .stall_i(stall),
    .tx_ready_o(tx_ready), .rx_char_o(rx_char));

  task automatic report_and_stop;
    if (fail_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Interrupt is looked at one edge later, once the launching edge has settled
  task automatic chk_irq(input logic exp);
    @(posedge clk_i);
    check("irq", {31'h0, irq}, {31'h0, exp});
  endtask

  // One single transfer; read data lands in rd
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk_i); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rdc(input string name, input logic [31:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0000_0000);
    check(name, rd, exp);
  endtask

  task automatic push(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++) begin
      wr(sfq_pkg::TX_DATA_ADDR, {24'h000000, base + 8'(i)});
    end
  endtask

  task automatic drain_tx;
    stall <= 1'b0;
    repeat (60) if (tx_char.valid === 1'b1) @(posedge clk_i);
    stall <= 1'b1;
    check("tx_valid", {31'h0, tx_char.valid}, 32'h0);
  endtask

  task automatic t_reset;
    rdc("tx_ctrl", sfq_pkg::TX_CTRL_ADDR, 32'h0000_A080);
    rdc("rx_ctrl", sfq_pkg::RX_CTRL_ADDR, 32'h0000_201F);
    rdc("unmapped", 32'h0000_0000, 32'h0000_0000);
    check("hresp", {31'h0, hresp}, 32'h0);
    check("irq", {31'h0, irq}, 32'h0);
  endtask

  task automatic t_irq;
    wr(sfq_pkg::IRQ_MASK_ADDR, 32'h0000_0001);
    chk_irq(1'b1);
    rdc("imask", sfq_pkg::IRQ_MASK_ADDR, 32'h0000_0001);
    rdc("tx_ctrl", sfq_pkg::TX_CTRL_ADDR, 32'h0000_A0A0);
    wr(sfq_pkg::IRQ_MASK_ADDR, 32'h0000_0000);
    chk_irq(1'b0);
  endtask

  task automatic t_tx_level;
    push(4, 8'hA0);
    wr(sfq_pkg::TX_CTRL_ADDR, 32'h0000_A043);
    rdc("tx_ctrl", sfq_pkg::TX_CTRL_ADDR, 32'h0000_A403);
    stall <= 1'b0;
    @(posedge clk_i);
    stall <= 1'b1;
    rdc("tx_ctrl", sfq_pkg::TX_CTRL_ADDR, 32'h0000_A383);
    wr(sfq_pkg::TX_CTRL_ADDR, 32'h0000_A023);
    chk_irq(1'b1);
    rdc("istat", sfq_pkg::IRQ_STAT_ADDR, 32'h0000_0001);
    wr(sfq_pkg::TX_CTRL_ADDR, 32'h0000_A003);
    chk_irq(1'b0);
    wr(sfq_pkg::IRQ_STAT_ADDR, 32'h0000_0001);
    rdc("istat_hold", sfq_pkg::IRQ_STAT_ADDR, 32'h0000_0001);
    wr(sfq_pkg::TX_CTRL_ADDR, 32'h0000_A002);
    wr(sfq_pkg::IRQ_STAT_ADDR, 32'h0000_0001);
    rdc("istat_clr", sfq_pkg::IRQ_STAT_ADDR, 32'h0000_0000);
    drain_tx();
    check("tx_taken", 32'(i_model.taken_q.size()), 32'd4);
    check("tx_first", {24'h0, i_model.taken_q[0]}, 32'h0000_00A0);
    check("tx_last", {24'h0, i_model.taken_q[3]}, 32'h0000_00A3);
    wr(sfq_pkg::TX_CTRL_ADDR, 32'h0000_A000);
  endtask

  task automatic t_tx_full;
    i_model.taken_q.delete();
    push(17, 8'h00);
    rdc("tx_ctrl", sfq_pkg::TX_CTRL_ADDR, 32'h0000_B080);
    drain_tx();
    check("tx_taken", 32'(i_model.taken_q.size()), 32'd16);
    check("tx_last", {24'h0, i_model.taken_q[15]}, 32'h0000_000F);
    push(2, 8'h50);
    wr(sfq_pkg::TX_CTRL_ADDR, 32'h0000_8000);
    rdc("tx_ctrl", sfq_pkg::TX_CTRL_ADDR, 32'h0000_8080);
    check("tx_valid", {31'h0, tx_char.valid}, 32'h0);
    wr(sfq_pkg::TX_CTRL_ADDR, 32'h0000_A000);
    rdc("tx_ctrl", sfq_pkg::TX_CTRL_ADDR, 32'h0000_A080);
  endtask

  task automatic t_rx_level;
    wr(sfq_pkg::RX_CTRL_ADDR, 32'h0000_2024);
    i_model.send(3, 8'h30);
    rdc("rx_ctrl", sfq_pkg::RX_CTRL_ADDR, 32'h0000_2324);
    check("irq", {31'h0, irq}, 32'h0);
    i_model.send(1, 8'h33);
    rdc("rx_ctrl", sfq_pkg::RX_CTRL_ADDR, 32'h0000_24A4);
    check("irq", {31'h0, irq}, 32'h1);
    rdc("rx_data", sfq_pkg::RX_DATA_ADDR, 32'h0000_0030);
    rdc("rx_ctrl", sfq_pkg::RX_CTRL_ADDR, 32'h0000_23A4);
    wr(sfq_pkg::RX_CTRL_ADDR, 32'h0000_2064);
    rdc("rx_ctrl", sfq_pkg::RX_CTRL_ADDR, 32'h0000_2324);
    check("irq", {31'h0, irq}, 32'h0);
    for (int i = 1; i < 4; i++) begin
      rdc("rx_data", sfq_pkg::RX_DATA_ADDR, 32'h30 + 32'(i));
    end
    rdc("rx_empty", sfq_pkg::RX_DATA_ADDR, 32'h0000_0033);
    rdc("rx_ctrl", sfq_pkg::RX_CTRL_ADDR, 32'h0000_2024);
  endtask

  task automatic t_rx_ovf;
    wr(sfq_pkg::RX_CTRL_ADDR, 32'h0000_203F);
    i_model.send(17, 8'h40);
    rdc("rx_ctrl", sfq_pkg::RX_CTRL_ADDR, 32'h0000_B03F);
    check("irq", {31'h0, irq}, 32'h0);
    rdc("rx_data", sfq_pkg::RX_DATA_ADDR, 32'h0000_0041);
    wr(sfq_pkg::RX_CTRL_ADDR, 32'h0000_603F);
    rdc("rx_ctrl", sfq_pkg::RX_CTRL_ADDR, 32'h0000_2F3F);
    wr(sfq_pkg::RX_CTRL_ADDR, 32'h0000_003F);
    i_model.send(1, 8'h60);
    rdc("rx_ctrl", sfq_pkg::RX_CTRL_ADDR, 32'h0000_003F);
    wr(sfq_pkg::RX_CTRL_ADDR, 32'h0000_201F);
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_irq();
    t_tx_level();
    t_tx_full();
    t_rx_level();
    t_rx_ovf();
    report_and_stop();
  end

  initial begin
    #1000000;
    fail_count++;
    report_and_stop();
  end
endmodule // tb_serial_port_fifo_status_irq
